/* logic/rair_regs.v */
/*
  Radio auxiliary control, event flag and calibration register bank.
  Assumes a byte-wide register port synchronous to clk, event inputs as
  one-cycle pulses and status inputs as levels from the analog and
  calibration blocks, all synchronous to clk.
*/
// Overview of operation
// - aux bit 1 powers temperature sensor
// - aux bit 0 powers supply monitor
// - converter result split across two readbacks
// - trip level is 1.7 V + 62 mV*(n+1)
// - supply below trip sets secondary bit 7
// - clock output is crystal over divisor, zero off
// - gain tick every 16 times divider clocks
// - wake count reaching limit sets primary bit 7
// - listen signal above threshold sets bit 6
// - cipher completion sets bit 5 when loaded
// - transmit done sets bit 4, packet mode
// - address match sets bit 3, packet mode
// - checksum good sets bit 2, packet mode
// - sync word found sets bit 1
// - preamble found sets bit 0
// - secondary bits 6,4,1,0 flag command events
// - calibration enables for synth and filter
// - synth status bit reads tuning done
// - filter status bit valid while enabled
// - baseband tuning word read back after cycle
`timescale 1ns/100ps
`include "rair_map.vh"

module rair_regs #(
  parameter WAKE_W = 16
) (
  input wire clk,                            // 125 MHz clock
  input wire resetn,                         // async reset, active low
  input wire ce,                             // clock enable, freezes state
  input wire [9:0] host_addr,                // register byte address
  input wire host_wr,                        // write strobe
  input wire [7:0] host_wdata,               // write data
  input wire host_rd,                        // read strobe
  output reg [7:0] host_rdata,               // read data
  output reg host_rvalid,                    // read data valid pulse
  output reg temp_sensor_enable,             // temperature monitor power
  output reg supply_monitor_enable,          // battery monitor power
  input wire [7:0] conv_result,              // converter result
  input wire conv_valid,                     // converter result strobe
  input wire [11:0] supply_mv,               // measured supply in mV
  input wire supply_mv_valid,                // supply measurement strobe
  output reg [4:0] supply_trip_level,        // alarm threshold field
  output reg [11:0] supply_trip_mv,          // trip voltage in mV
  output wire clock_output_pin,              // divided crystal clock
  input wire fsk_mode,                       // frequency-shift mode active
  output wire gain_loop_tick,                // gain control update pulse
  input wire wake_event,                     // one timer wake-up
  input wire [WAKE_W-1:0] wake_count_limit,  // wake-ups before flag
  input wire wake_count_clear,               // restart wake counting
  input wire listen_mode,                    // low-power wake listening
  input wire [7:0] listen_rssi,              // measured signal strength
  input wire listen_rssi_valid,              // signal strength strobe
  input wire [7:0] listen_signal_threshold,  // listen detect threshold
  input wire cipher_loaded,                  // cipher firmware present
  input wire cipher_done,                    // cipher command complete
  input wire packet_mode,                    // packet handling active
  input wire tx_done,                        // packet transmitted
  input wire addr_match,                     // received address matched
  input wire crc_ok,                         // received checksum good
  input wire sync_found,                     // sync word qualified
  input wire preamble_found,                 // preamble qualified
  input wire cmd_ready,                      // processor takes command
  input wire wake_timer_expired,             // wake timer timeout
  input wire port_ready,                     // serial port ready
  input wire cmd_done,                       // command finished
  output reg synth_tuning_enable,            // synth calibration enable
  output reg baseband_filter_tuning_enable,  // filter calibration enable
  input wire synth_tuning_done,              // synth calibration finished
  input wire baseband_filter_tuning_done,    // filter calibration finished
  input wire amplifier_ramp_done,            // amplifier ramp finished
  input wire [5:0] baseband_tuning_word      // filter calibration result
);

  // ************************************************************
  // configuration registers
  // ************************************************************
  reg [3:0] host_clock_divisor;
  reg [7:0] gain_loop_divisor;
  reg [7:0] conv_reg;
  reg [7:0] evt_pri_reg;
  reg [7:0] evt_sec_reg;
  reg [2:0] cal_stat_reg;
  reg [5:0] bb_word_reg;
  reg bb_done_d_reg;
  reg [WAKE_W-1:0] wake_counter;

  wire wr_aux = host_wr && (host_addr == `RAIR_OFS_AUX_PWR);
  wire wr_batt = host_wr && (host_addr == `RAIR_OFS_BATT_THR);
  wire wr_clkout = host_wr && (host_addr == `RAIR_OFS_CLKOUT_DIV);
  wire wr_gain = host_wr && (host_addr == `RAIR_OFS_GAIN_DIV);
  wire wr_pri = host_wr && (host_addr == `RAIR_OFS_EVT_PRI);
  wire wr_sec = host_wr && (host_addr == `RAIR_OFS_EVT_SEC);
  wire wr_cal = host_wr && (host_addr == `RAIR_OFS_CAL_EN);

  // only defined fields are stored; reserved bits are never kept
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      temp_sensor_enable <= 1'b0;
      supply_monitor_enable <= 1'b0;
      supply_trip_level <= `RAIR_RST_BATT_THR;
      host_clock_divisor <= `RAIR_RST_CLKOUT_DIV;
      gain_loop_divisor <= `RAIR_RST_GAIN_DIV;
      synth_tuning_enable <= 1'b0;
      baseband_filter_tuning_enable <= 1'b0;
    end else if (ce) begin
      if (wr_aux) begin
        temp_sensor_enable <= host_wdata[`RAIR_AUX_TEMP_BIT];
        supply_monitor_enable <= host_wdata[`RAIR_AUX_SUPPLY_BIT];
      end
      if (wr_batt) begin
        supply_trip_level <= host_wdata[`RAIR_BATT_FIELD];
      end
      if (wr_clkout) begin
        host_clock_divisor <= host_wdata[`RAIR_CLKOUT_FIELD];
      end
      if (wr_gain) begin
        gain_loop_divisor <= host_wdata;
      end
      if (wr_cal) begin
        synth_tuning_enable <= host_wdata[`RAIR_CAL_SYNTH_BIT];
        baseband_filter_tuning_enable <= host_wdata[`RAIR_CAL_BB_BIT];
      end
    end
  end

  // ************************************************************
  // supply trip voltage and alarm
  // ************************************************************
  wire [11:0] trip_next = `RAIR_BATT_BASE_MV +
    `RAIR_BATT_STEP_MV * ({7'h00, supply_trip_level} + `RAIR_BATT_ONE);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      supply_trip_mv <= `RAIR_BATT_BASE_MV + `RAIR_BATT_STEP_MV;
    end else if (ce) begin
      supply_trip_mv <= trip_next;
    end
  end

  // compares against the registered level, one cycle behind a write
  wire supply_alarm = supply_monitor_enable && supply_mv_valid &&
    (supply_mv < supply_trip_mv);

  // ************************************************************
  // clock output and gain loop tick
  // ************************************************************
  rair_clk_div #(
    .W(4)
  ) u_clkout (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .divisor(host_clock_divisor),
    .clk_out(clock_output_pin),
    .tick()
  );

  // gated to zero outside frequency-shift modes, which stops the tick
  wire [11:0] gain_ratio = fsk_mode ?
    {gain_loop_divisor, `RAIR_GAIN_PRESCALE_BITS} : 12'h000;

  rair_clk_div #(
    .W(12)
  ) u_gain (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .divisor(gain_ratio),
    .clk_out(),
    .tick(gain_loop_tick)
  );

  // ************************************************************
  // wake-up counter
  // ************************************************************
  wire [WAKE_W-1:0] wake_one = {{(WAKE_W-1){1'b0}}, 1'b1};
  wire [WAKE_W-1:0] wake_inc = wake_counter + wake_one;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_counter <= {WAKE_W{1'b0}};
    end else if (ce) begin
      if (wake_count_clear) begin
        wake_counter <= {WAKE_W{1'b0}};
      end else if (wake_event) begin
        wake_counter <= wake_inc;
      end
    end
  end

  // fires once, on the wake-up that makes the count equal the limit
  wire wake_reached = wake_event && !wake_count_clear &&
    (wake_inc == wake_count_limit);

  // ************************************************************
  // event flags
  // ************************************************************
  wire [15:0] evt_set;
  wire [15:0] evt_clr;
  wire [15:0] evt_cur = {evt_sec_reg, evt_pri_reg};
  wire [15:0] evt_next;

  assign evt_set[`RAIR_EP_WAKE_COUNT] = wake_reached;
  assign evt_set[`RAIR_EP_LISTEN] = listen_mode && listen_rssi_valid &&
    (listen_rssi > listen_signal_threshold);
  assign evt_set[`RAIR_EP_CIPHER] = cipher_loaded && cipher_done;
  assign evt_set[`RAIR_EP_TX_DONE] = packet_mode && tx_done;
  assign evt_set[`RAIR_EP_ADDR] = packet_mode && addr_match;
  assign evt_set[`RAIR_EP_CRC] = packet_mode && crc_ok;
  assign evt_set[`RAIR_EP_SYNC] = sync_found;
  assign evt_set[`RAIR_EP_PREAMBLE] = preamble_found;
  assign evt_set[8 + `RAIR_ES_BATTERY] = supply_alarm;
  assign evt_set[8 + `RAIR_ES_CMD_READY] = cmd_ready;
  assign evt_set[8 + 5] = 1'b0;
  assign evt_set[8 + `RAIR_ES_WAKE_TIMER] = wake_timer_expired;
  assign evt_set[8 + 3] = 1'b0;
  assign evt_set[8 + 2] = 1'b0;
  assign evt_set[8 + `RAIR_ES_PORT_READY] = port_ready;
  assign evt_set[8 + `RAIR_ES_CMD_DONE] = cmd_done;

  // write one to clear; unused secondary bits stay zero
  assign evt_clr = {(wr_sec ? (host_wdata & `RAIR_ES_USED_MASK) : 8'h00),
                    (wr_pri ? host_wdata : 8'h00)};

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_flag
      // a set in the clearing cycle wins so no event is lost
      assign evt_next[i] = evt_set[i] | (evt_cur[i] & ~evt_clr[i]);
    end
  endgenerate

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_pri_reg <= `RAIR_RST_EVT;
      evt_sec_reg <= `RAIR_RST_EVT;
    end else if (ce) begin
      evt_pri_reg <= evt_next[7:0];
      evt_sec_reg <= evt_next[15:8];
    end
  end

  // ************************************************************
  // converter result and calibration status capture
  // ************************************************************
  wire bb_done_rise = baseband_filter_tuning_done && !bb_done_d_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_reg <= `RAIR_RST_CONV;
      cal_stat_reg <= `RAIR_RST_CAL_STAT;
      bb_word_reg <= `RAIR_RST_BB_WORD;
      bb_done_d_reg <= 1'b0;
    end else if (ce) begin
      if (conv_valid) begin
        conv_reg <= conv_result;
      end
      cal_stat_reg[`RAIR_CAL_RAMP_BIT] <= amplifier_ramp_done;
      cal_stat_reg[`RAIR_CAL_SYNTH_BIT] <= synth_tuning_done;
      // filter done means nothing while its calibration is disabled
      cal_stat_reg[`RAIR_CAL_BB_BIT] <= baseband_filter_tuning_done &&
        baseband_filter_tuning_enable;
      bb_done_d_reg <= baseband_filter_tuning_done;
      if (bb_done_rise && baseband_filter_tuning_enable) begin
        bb_word_reg <= baseband_tuning_word;
      end
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  reg [7:0] rd_mux;

  // unmapped addresses and reserved bits read zero
  always @* begin
    rd_mux = 8'h00;
    case (host_addr)
      `RAIR_OFS_AUX_PWR: begin
        rd_mux = {6'h00, temp_sensor_enable, supply_monitor_enable};
      end
      `RAIR_OFS_CONV_HI: begin
        rd_mux = {2'h0, conv_reg[`RAIR_CONV_HI_FIELD]};
      end
      `RAIR_OFS_CONV_LO: begin
        rd_mux = {conv_reg[`RAIR_CONV_LO_FIELD], 6'h00};
      end
      `RAIR_OFS_BATT_THR: begin
        rd_mux = {3'h0, supply_trip_level};
      end
      `RAIR_OFS_CLKOUT_DIV: begin
        rd_mux = {4'h0, host_clock_divisor};
      end
      `RAIR_OFS_GAIN_DIV: begin
        rd_mux = gain_loop_divisor;
      end
      `RAIR_OFS_EVT_PRI: begin
        rd_mux = evt_pri_reg;
      end
      `RAIR_OFS_EVT_SEC: begin
        rd_mux = evt_sec_reg;
      end
      `RAIR_OFS_CAL_EN: begin
        rd_mux = {6'h00, synth_tuning_enable, baseband_filter_tuning_enable};
      end
      `RAIR_OFS_CAL_STAT: begin
        rd_mux = {5'h00, cal_stat_reg};
      end
      `RAIR_OFS_BB_WORD: begin
        rd_mux = {2'h0, bb_word_reg};
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else if (ce) begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        host_rdata <= rd_mux;
      end
    end
  end

endmodule

/* pkg/rair_map.vh */
/*
  Register map, field positions, reset values and constants of the radio
  auxiliary, event and calibration register bank.
  Assumes it is included by bare name into the design files that need it.
*/
`ifndef RAIR_MAP_VH
`define RAIR_MAP_VH

// ************************************************************
// register offsets (10-bit byte addresses)
// ************************************************************
`define RAIR_ADDR_W 10
`define RAIR_OFS_AUX_PWR 10'h325
`define RAIR_OFS_CONV_HI 10'h327
`define RAIR_OFS_CONV_LO 10'h328
`define RAIR_OFS_BATT_THR 10'h32D
`define RAIR_OFS_CLKOUT_DIV 10'h32E
`define RAIR_OFS_GAIN_DIV 10'h32F
`define RAIR_OFS_EVT_PRI 10'h336
`define RAIR_OFS_EVT_SEC 10'h337
`define RAIR_OFS_CAL_EN 10'h338
`define RAIR_OFS_CAL_STAT 10'h339
`define RAIR_OFS_BB_WORD 10'h345

// ************************************************************
// reset values
// ************************************************************
`define RAIR_RST_AUX_PWR 2'h0
`define RAIR_RST_BATT_THR 5'h00
`define RAIR_RST_CLKOUT_DIV 4'h4
`define RAIR_RST_GAIN_DIV 8'h28
`define RAIR_RST_EVT 8'h00
`define RAIR_RST_CAL_EN 2'h0
`define RAIR_RST_CAL_STAT 3'h0
`define RAIR_RST_BB_WORD 6'h00
`define RAIR_RST_CONV 8'h00

// ************************************************************
// field positions
// ************************************************************
`define RAIR_AUX_TEMP_BIT 1
`define RAIR_AUX_SUPPLY_BIT 0
`define RAIR_AUX_FIELD 1:0
`define RAIR_CONV_HI_FIELD 7:2
`define RAIR_CONV_LO_FIELD 1:0
`define RAIR_BATT_FIELD 4:0
`define RAIR_CLKOUT_FIELD 3:0
`define RAIR_CAL_SYNTH_BIT 1
`define RAIR_CAL_BB_BIT 0
`define RAIR_CAL_RAMP_BIT 2
`define RAIR_CAL_FIELD 1:0
`define RAIR_BB_WORD_FIELD 5:0

// primary event flags
`define RAIR_EP_WAKE_COUNT 7
`define RAIR_EP_LISTEN 6
`define RAIR_EP_CIPHER 5
`define RAIR_EP_TX_DONE 4
`define RAIR_EP_ADDR 3
`define RAIR_EP_CRC 2
`define RAIR_EP_SYNC 1
`define RAIR_EP_PREAMBLE 0
// secondary event flags
`define RAIR_ES_BATTERY 7
`define RAIR_ES_CMD_READY 6
`define RAIR_ES_WAKE_TIMER 4
`define RAIR_ES_PORT_READY 1
`define RAIR_ES_CMD_DONE 0
`define RAIR_ES_USED_MASK 8'hD3

// ************************************************************
// supply trip level: base + step * (field + 1), in mV
// ************************************************************
`define RAIR_TRIP_W 12
`define RAIR_BATT_BASE_MV 12'h6A4
`define RAIR_BATT_STEP_MV 12'h03E
`define RAIR_BATT_ONE 12'h001

// gain loop tick period is the divider times 16, these four zero bits appended below it
`define RAIR_GAIN_PRESCALE_BITS 4'h0

`endif

/* logic/rair_clk_div.v */
/*
  Programmable integer clock divider with a divided level and a tick.
  Assumes the reference clock is clk and that a divisor of zero stops it.
*/
`timescale 1ns/100ps

module rair_clk_div #(
  parameter W = 4
) (
  input wire clk,               // reference clock
  input wire resetn,            // async reset, active low
  input wire ce,                // clock enable, freezes state
  input wire [W-1:0] divisor,   // division ratio, zero stops
  output reg clk_out,           // divided clock level
  output reg tick               // one pulse per output period
);

  reg [W-1:0] cnt_reg;
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] half = divisor >> 1;
  wire wrap = (cnt_reg >= (divisor - one));
  wire [W-1:0] cnt_next = wrap ? {W{1'b0}} : (cnt_reg + one);

  // odd ratios give a duty just under half; ratio one only ticks
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= {W{1'b0}};
      clk_out <= 1'b0;
      tick <= 1'b0;
    end else if (ce) begin
      if (divisor == {W{1'b0}}) begin
        cnt_reg <= {W{1'b0}};
        clk_out <= 1'b0;
        tick <= 1'b0;
      end else begin
        cnt_reg <= cnt_next;
        clk_out <= (cnt_next < half);
        tick <= wrap;
      end
    end
  end

endmodule

/* sim/rair_regs_checker.sv */
/* Concurrent checks on the ports of the register bank.
   Assumes it is bound into rair_regs and that clk is the only clock. */
`timescale 1ns/100ps
module rair_regs_checker (
  input wire clk, // clock
  input wire resetn, // reset, active low
  input wire ce, // clock enable
  input wire [9:0] host_addr, // address
  input wire host_wr, // write strobe
  input wire [7:0] host_wdata, // write data
  input wire host_rd, // read strobe
  input wire [7:0] host_rdata, // read data
  input wire host_rvalid, // read valid
  input wire temp_sensor_enable, // temp power
  input wire supply_monitor_enable, // supply power
  input wire [4:0] supply_trip_level, // trip field
  input wire [11:0] supply_trip_mv, // trip mV
  input wire fsk_mode, // tick enable
  input wire gain_loop_tick // gain tick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  temp_enable_a: assert property (
    ce && host_wr && host_addr == 10'h325 |=> temp_sensor_enable == $past(host_wdata[1]))
    else $error("temp enable wrong");
  supply_enable_a: assert property (
    ce && host_wr && host_addr == 10'h325 |=> supply_monitor_enable == $past(host_wdata[0]))
    else $error("supply enable wrong");
  trip_field_a: assert property (
    ce && host_wr && host_addr == 10'h32D |=> supply_trip_level == $past(host_wdata[4:0]))
    else $error("trip field wrong");
  // trip voltage is registered, so only judged once the field has settled
  trip_volts_a: assert property (
    $stable(supply_trip_level) |->
    supply_trip_mv == 12'h6A4 + 12'h03E * ({7'h00, supply_trip_level} + 12'h001))
    else $error("trip voltage wrong");
  read_latency_a: assert property (
    ce && host_rd |=> host_rvalid)
    else $error("read valid missing");
  aux_reserved_a: assert property (
    host_rvalid && $past(host_addr) == 10'h325 |-> host_rdata[7:2] == 6'h00)
    else $error("aux reserved bits set");
  sec_unused_a: assert property (
    host_rvalid && $past(host_addr) == 10'h337 |-> (host_rdata & 8'h2C) == 8'h00)
    else $error("unused event bits set");
  tick_off_a: assert property (
    !fsk_mode [*2] |-> !gain_loop_tick)
    else $error("tick outside fsk mode");
  tick_pulse_a: assert property (
    gain_loop_tick && ce |=> !gain_loop_tick)
    else $error("tick longer than one cycle");
endmodule

bind rair_regs rair_regs_checker u_rair_regs_checker (
  .clk(clk), .resetn(resetn), .ce(ce), .host_addr(host_addr), .host_wr(host_wr),
  .host_wdata(host_wdata), .host_rd(host_rd), .host_rdata(host_rdata),
  .host_rvalid(host_rvalid), .temp_sensor_enable(temp_sensor_enable),
  .supply_monitor_enable(supply_monitor_enable), .supply_trip_level(supply_trip_level),
  .supply_trip_mv(supply_trip_mv), .fsk_mode(fsk_mode), .gain_loop_tick(gain_loop_tick));

/* sim/rair_radio_model.sv */
/* Behavioural radio core: event pulses on request and two tuning engines.
   Assumes requests come from the bench synchronous to clk. */
`timescale 1ns/100ps
module rair_radio_model #(
  parameter CAL_CYCLES = 20,
  parameter [5:0] TUNE_WORD = 6'h2D
) (
  input wire clk, // clock
  input wire resetn, // reset, active low
  input wire fire, // event request
  input wire [9:0] fire_sel, // events wanted
  input wire synth_en, // synth tuning enable
  input wire bb_en, // filter tuning enable
  output reg [9:0] ev, // one-cycle event pulses
  output reg synth_done, // synth tuning done
  output reg bb_done, // filter tuning done
  output reg [5:0] bb_word // filter tuning word
);
  reg [7:0] synth_cnt_reg;
  reg [7:0] bb_cnt_reg;

  // ev: preamble, sync, crc, addr, tx, cipher, cmd done, port, wake timer, cmd ready
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev <= 10'h000;
      synth_cnt_reg <= 8'h00;
      bb_cnt_reg <= 8'h00;
      synth_done <= 1'b0;
      bb_done <= 1'b0;
      bb_word <= 6'h15;
    end else begin
      ev <= fire ? fire_sel : 10'h000;
      synth_cnt_reg <= !synth_en ? 8'h00 : synth_cnt_reg + {7'h00, synth_cnt_reg < CAL_CYCLES};
      bb_cnt_reg <= !bb_en ? 8'h00 : bb_cnt_reg + {7'h00, bb_cnt_reg < CAL_CYCLES};
      synth_done <= synth_en && synth_cnt_reg == CAL_CYCLES;
      bb_done <= bb_en && bb_cnt_reg == CAL_CYCLES;
      // word toggles until valid so a stale capture is caught
      bb_word <= (bb_en && bb_cnt_reg == CAL_CYCLES) ? TUNE_WORD : ~bb_word;
    end
  end
endmodule

/* sim/test_rair_regs.sv */
/* Self-checking bench for the register bank with the radio model.
   Assumes the checker is bound in and inputs change 1 ns after the edge. */
`timescale 1ns/100ps
module test_rair_regs;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [9:0] host_addr = 10'h000;
  reg host_wr = 1'b0;
  reg [7:0] host_wdata = 8'h00;
  reg host_rd = 1'b0;
  reg ce = 1'b1;
  reg [3:0] stb = 4'h0;
  reg [7:0] conv_result = 8'hB5;
  reg [11:0] supply_mv = 12'hFFF;
  reg fsk_mode = 1'b0;
  reg listen_mode = 1'b0;
  reg [7:0] listen_rssi = 8'h00;
  reg packet_mode = 1'b1;
  reg cipher_loaded = 1'b1;
  reg amp_done = 1'b0;
  reg fire = 1'b0;
  reg [9:0] fire_sel = 10'h000;
  reg [7:0] rdv = 8'h00;
  wire [7:0] host_rdata;
  wire host_rvalid, temp_en, supply_en, clock_output_pin, gain_loop_tick, synth_en, bb_en;
  wire [4:0] supply_trip_level;
  wire [11:0] supply_trip_mv;
  wire [9:0] ev;
  wire synth_done, bb_done;
  wire [5:0] bb_word;
  integer errors = 0;
  integer comparisons = 0;
  integer n;
  integer i;

  always #4 clk = ~clk;

  rair_regs u_rair_regs (.clk(clk), .resetn(resetn), .ce(ce), .host_addr(host_addr),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rd(host_rd), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .temp_sensor_enable(temp_en), .supply_monitor_enable(supply_en),
    .conv_result(conv_result), .conv_valid(stb[0]), .supply_mv(supply_mv),
    .supply_mv_valid(stb[1]), .supply_trip_level(supply_trip_level),
    .supply_trip_mv(supply_trip_mv), .clock_output_pin(clock_output_pin), .fsk_mode(fsk_mode),
    .gain_loop_tick(gain_loop_tick), .wake_event(stb[3]), .wake_count_limit(16'h0003),
    .wake_count_clear(1'b0), .listen_mode(listen_mode), .listen_rssi(listen_rssi),
    .listen_rssi_valid(stb[2]), .listen_signal_threshold(8'h50), .cipher_loaded(cipher_loaded),
    .cipher_done(ev[5]), .packet_mode(packet_mode), .tx_done(ev[4]), .addr_match(ev[3]),
    .crc_ok(ev[2]), .sync_found(ev[1]), .preamble_found(ev[0]), .cmd_ready(ev[9]),
    .wake_timer_expired(ev[8]), .port_ready(ev[7]), .cmd_done(ev[6]),
    .synth_tuning_enable(synth_en), .baseband_filter_tuning_enable(bb_en),
    .synth_tuning_done(synth_done), .baseband_filter_tuning_done(bb_done),
    .amplifier_ramp_done(amp_done), .baseband_tuning_word(bb_word));

  rair_radio_model u_rair_radio_model (.clk(clk), .resetn(resetn), .fire(fire),
    .fire_sel(fire_sel), .synth_en(synth_en), .bb_en(bb_en), .ev(ev), .synth_done(synth_done),
    .bb_done(bb_done), .bb_word(bb_word));

  // ********************
  // access tasks
  // ********************
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    begin
      @(posedge clk) #1;
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(posedge clk) #1;
      host_wr = 1'b0;
    end
  endtask
  task rd(input [9:0] a);
    begin
      @(posedge clk) #1;
      host_addr = a;
      host_rd = 1'b1;
      @(posedge clk) #1;
      host_rd = 1'b0;
      rdv = host_rvalid ? host_rdata : 8'hXX;
    end
  endtask
  task rc(input [9:0] a, input [7:0] e);
    begin
      rd(a);
      chk({8'h00, rdv}, {8'h00, e});
    end
  endtask
  task pls(input [3:0] s, input [9:0] f);
    begin
      @(posedge clk) #1;
      stb = s;
      fire_sel = f;
      fire = |f;
      @(posedge clk) #1;
      stb = 4'h0;
      fire = 1'b0;
    end
  endtask
  task cko(input [7:0] d, input [15:0] e);
    begin
      wr(10'h32E, d);
      repeat (6) @(posedge clk);
      n = 0;
      repeat (20) begin
        @(posedge clk) #1;
        n = n + clock_output_pin;
      end
      chk(n, e);
    end
  endtask
  task end_of_test;
    begin
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  initial begin
    #80000;
    errors = errors + 1;
    end_of_test;
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    rc(10'h325, 8'h00);
    rc(10'h327, 8'h00);
    rc(10'h32D, 8'h00);
    rc(10'h32E, 8'h04);
    rc(10'h32F, 8'h28);
    rc(10'h336, 8'h00);
    rc(10'h337, 8'h00);
    rc(10'h338, 8'h00);
    rc(10'h339, 8'h00);
    rc(10'h345, 8'h00);
    $display("test reset values done");
    wr(10'h325, 8'hFF);
    chk({temp_en, supply_en}, 2'h3);
    rc(10'h325, 8'h03);
    wr(10'h32D, 8'hFF);
    rc(10'h32D, 8'h1F);
    chk(supply_trip_mv, 12'h6A4 + 12'h03E * (12'h01F + 12'h001));
    wr(10'h32F, 8'hFF);
    rc(10'h32F, 8'hFF);
    wr(10'h338, 8'hFC);
    rc(10'h338, 8'h00);
    wr(10'h327, 8'hFF);
    rc(10'h327, 8'h00);
    wr(10'h345, 8'hFF);
    rc(10'h345, 8'h00);
    wr(10'h326, 8'hFF);
    rc(10'h326, 8'h00);
    wr(10'h325, 8'h00);
    chk({temp_en, supply_en}, 2'h0);
    pls(4'h1, 10'h000);
    rc(10'h327, 8'h2D);
    rc(10'h328, 8'h40);
    $display("test access done");
    pls(4'h0, 10'h03F);
    rc(10'h336, 8'h3F);
    wr(10'h336, 8'hFF);
    rc(10'h336, 8'h00);
    packet_mode = 1'b0;
    cipher_loaded = 1'b0;
    pls(4'h0, 10'h03F);
    rc(10'h336, 8'h03);
    wr(10'h336, 8'h03);
    pls(4'h0, 10'h3C0);
    rc(10'h337, 8'h53);
    wr(10'h337, 8'hFF);
    listen_mode = 1'b1;
    listen_rssi = 8'h50;
    pls(4'h4, 10'h000);
    rc(10'h336, 8'h00);
    listen_rssi = 8'h51;
    pls(4'h4, 10'h000);
    rc(10'h336, 8'h40);
    wr(10'h336, 8'h40);
    pls(4'h8, 10'h000);
    pls(4'h8, 10'h000);
    rc(10'h336, 8'h00);
    pls(4'h8, 10'h000);
    rc(10'h336, 8'h80);
    wr(10'h325, 8'h01);
    ce = 1'b0;
    wr(10'h325, 8'h02);
    ce = 1'b1;
    chk({temp_en, supply_en}, 2'h1);
    supply_mv = 12'hE64;
    pls(4'h2, 10'h000);
    rc(10'h337, 8'h00);
    supply_mv = 12'hE63;
    pls(4'h2, 10'h000);
    rc(10'h337, 8'h80);
    $display("test events done");
    cko(8'h04, 16'h000A);
    cko(8'h00, 16'h0000);
    cko(8'h05, 16'h0008);
    wr(10'h32F, 8'h01);
    fsk_mode = 1'b1;
    for (n = 0; n < 700 && gain_loop_tick !== 1'b1; n = n + 1) @(posedge clk) #1;
    chk(n < 700, 16'h0001);
    for (n = 1; n < 40; n = n + 1) begin
      @(posedge clk) #1;
      if (gain_loop_tick === 1'b1) break;
    end
    chk(n, 16'h0010);
    fsk_mode = 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge clk) #1;
      n = n + gain_loop_tick;
    end
    chk(n, 16'h0000);
    $display("test dividers done");
    wr(10'h338, 8'h03);
    chk({synth_en, bb_en}, 2'h3);
    rc(10'h339, 8'h00);
    amp_done = 1'b1;
    for (i = 0; i < 40 && rdv !== 8'h07; i = i + 1) rd(10'h339);
    chk(rdv, 8'h07);
    rc(10'h345, 8'h2D);
    wr(10'h338, 8'h02);
    rc(10'h339, 8'h06);
    $display("test calibration done");
    end_of_test;
  end
endmodule
